/* File: rom_id_and_transfer_status_tb_top.sv */
`timescale 1ns/1ps
module rom_id_and_transfer_status_tb_top;
	localparam logic [7:0]  FAM = 8'h5A;              // arbitrary value, identity built in by default
	localparam logic [47:0] SER = 48'h0123_4567_89AB; // arbitrary value, identity built in by default
	typedef struct packed {logic copy; logic pwr; logic [7:0] st;} rts_row_t;
	logic        clk_in, reset_n_in, dq_in, copy_done_in, power_lost_in;
	logic        dq_out, dq_oe_out, overdrive_out, seen;
	logic [15:0] target_addr_out;
	logic [10:0] page_out;
	logic [7:0]  status_out;
	logic [63:0] rom_code;
	rts_row_t    rows [2];
	int          err_count = 0;
	int          checks = 0;

	// reset count kept above the overdrive reset so overdrive resets keep the speed
	// hold time stays at its default: no read slot runs at regular speed
	rts_top #(.RST_REG_CYC(5000), .PWAIT_REG_CYC(100), .PLEN_REG_CYC(200)) uut (
		.clk_in(clk_in), .reset_n_in(reset_n_in), .dq_in(dq_in),
		.copy_done_in(copy_done_in), .power_lost_in(power_lost_in),
		.dq_out(dq_out), .dq_oe_out(dq_oe_out), .overdrive_out(overdrive_out),
		.target_addr_out(target_addr_out), .page_out(page_out), .status_out(status_out));
	rts_master_model host (.clk_in(clk_in), .dev_pull_in(dq_oe_out),
		.ovd_in(overdrive_out), .dq_line_out(dq_in));

	// 250 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	//////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// reflected serial form of x8+x5+x4+1, zero start, low bit first
	function automatic logic [7:0] crc8_of(input logic [63:0] v, input int n);
		logic [7:0] c;
		logic       fb;
		c = 8'h00;
		for (int i = 0; i < n; i++) begin
			fb = c[0] ^ v[i];
			c = c >> 1;
			if (fb) c = c ^ 8'h8C;
		end
		return c;
	endfunction : crc8_of

	// overdrive session: reset pulse, then a ROM command, then write-scratchpad header
	task automatic od_write_hdr(input logic [7:0] lo, input logic [7:0] hi);
		host.bus_reset(4100, seen);
		host.write_byte(rts_pkg::CMD_SKIP_ROM);
		host.write_byte(rts_pkg::CMD_WR_SPAD);
		host.write_byte(lo);
		host.write_byte(hi);
	endtask : od_write_hdr

	task automatic end_of_test();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test

	// main sequence
	initial begin
		reset_n_in = 1'b0;
		copy_done_in = 1'b0;
		power_lost_in = 1'b0;
		rows[0] = '{1'b0, 1'b0, 8'h5F};
		rows[1] = '{1'b1, 1'b0, 8'hDF};
		rom_code = {crc8_of({8'h00, SER, FAM}, 56), SER, FAM};
		check({8'h00, crc8_of(rom_code, 64)}, 16'h0000, "code crc residue");
		repeat (10) @(posedge clk_in);
		check({8'h00, status_out}, 16'h0000, "status in reset");
		reset_n_in <= 1'b1;
		repeat (60) @(posedge clk_in);
		check({8'h00, status_out}, 16'h007F, "status after reset");
		host.bus_reset(5100, seen);
		check({15'h0, seen}, 16'h0001, "presence");
		check({15'h0, dq_out}, 16'h0000, "pin only pulls low");
		host.write_byte(rts_pkg::CMD_OD_MATCH);
		check({15'h0, overdrive_out}, 16'h0001, "overdrive entry");
		for (int i = 0; i < 8; i++) host.write_byte(rom_code[8*i +: 8]);
		host.write_byte(rts_pkg::CMD_WR_SPAD);
		host.write_byte(8'h2D);
		host.write_byte(8'h01);
		check(target_addr_out, 16'h0128, "match then address");
		check({5'h00, page_out}, 16'h0009, "page");
		for (int i = 0; i < 8; i++) host.write_byte(8'(8'h11 * i));
		host.bus_reset(4100, seen);
		check({8'h00, status_out}, 16'h005F, "full write");
		// table of flag events and the status they should leave
		foreach (rows[i]) begin
			copy_done_in <= rows[i].copy;
			power_lost_in <= rows[i].pwr;
			@(posedge clk_in);
			copy_done_in <= 1'b0;
			power_lost_in <= 1'b0;
			repeat (3) @(posedge clk_in);
			check({8'h00, status_out}, {8'h00, rows[i].st}, "status row");
		end
		// awkward: unaligned top address, one byte clears copy flag, then a broken byte
		od_write_hdr(8'hFF, 8'h03);
		check(target_addr_out, 16'h03F8, "forced alignment");
		check({5'h00, page_out}, 16'h001F, "top page");
		host.write_byte(8'hA5);
		check({8'h00, status_out}, 16'h005F, "byte clears copy flag");
		for (int i = 0; i < 3; i++) host.write_bit(1'b0);
		host.bus_reset(4100, seen);
		check({8'h00, status_out}, 16'h007F, "partial byte");
		check({15'h0, overdrive_out}, 16'h0001, "speed kept");
		power_lost_in <= 1'b1;
		@(posedge clk_in);
		power_lost_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		check({8'h00, status_out}, 16'h007F, "power loss");
		end_of_test();
	end

	// run needs about 0.65 ms; cut a hang well after that
	initial begin
		#1_000_000;
		err_count++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		end_of_test();
	end
endmodule : rom_id_and_transfer_status_tb_top

/* File: rts_crc.sv */
`timescale 1ns/1ps
// serial reflected CRC, one bit per enable, LSB of the data first
module rts_crc #(
	parameter int           W    = 8,
	parameter logic [W-1:0] POLY = '0
) (
	input  wire logic         clk_in,
	input  wire logic         reset_n_in,
	input  wire logic         clr_in,
	input  wire logic         en_in,
	input  wire logic         bit_in,
	output logic      [W-1:0] crc_out
);
	logic [W-1:0] crc_q;
	logic         fb;

	// feedback taps from the shifted-out bit
	assign fb      = crc_q[0] ^ bit_in;
	assign crc_out = crc_q;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			crc_q <= '0;
		end else if (clr_in) begin
			crc_q <= '0;
		end else if (en_in) begin
			crc_q <= (crc_q >> 1) ^ (fb ? POLY : '0);
		end
	end
endmodule : rts_crc

/* File: rts_master_model.sv */
`timescale 1ns/1ps
// bus host: open-drain pull with a pull-up, so a released line reads high
module rts_master_model (
	input  wire logic clk_in,
	input  wire logic dev_pull_in,
	input  wire logic ovd_in,
	output logic      dq_line_out
);
	logic host_low_q = 1'b0;

	// wired-AND of both parties; idle level is high between slots
	assign dq_line_out = !(host_low_q || dev_pull_in);

	// reset pulse, then watch for the device's presence answer
	task automatic bus_reset(input int low_cyc, output logic seen);
		seen = 1'b0;
		host_low_q <= 1'b1;
		repeat (low_cyc) @(posedge clk_in);
		host_low_q <= 1'b0;
		repeat (ovd_in ? 3200 : 400) begin
			@(posedge clk_in);
			if (dev_pull_in) seen = 1'b1;
		end
	endtask : bus_reset

	// one write slot; a 0 holds past the sample point, a 1 releases at once
	task automatic write_bit(input logic b);
		int s;
		s = ovd_in ? rts_pkg::SAMP_OD_CYC : rts_pkg::SAMP_REG_CYC;
		host_low_q <= 1'b1;
		repeat (b ? 3 : s + 10) @(posedge clk_in);
		host_low_q <= 1'b0;
		repeat (b ? s + 10 : 10) @(posedge clk_in);
	endtask : write_bit

	// bytes go out low bit first
	task automatic write_byte(input logic [7:0] v);
		for (int i = 0; i < 8; i++) write_bit(v[i]);
	endtask : write_byte
endmodule : rts_master_model

/* File: rts_pkg.sv */
// Summary of operation
// [RULE1] 64-bit code: family, 48-bit serial, CRC8
// [RULE2] CRC8 x8+x5+x4+1, zero start, LSB first
// [RULE3] checker shifting stored CRC ends at zero
// [RULE4] all bus bytes move LSB first
// [RULE5] ROM command precedes any function command
// [RULE6] overdrive ROM command switches to overdrive
// [RULE7] function commands only after ROM success
// [RULE8] master loads low then high address
// [RULE9] low three target address bits forced zero
// [RULE10] ending offset bits always read ones
// [RULE11] partial flag on odd bits or power loss
// [RULE12] complete scratchpad write clears partial flag
// [RULE13] status bits 3, 4, 6 read one
// [RULE14] copy done set by copy, cleared by write
// [RULE15] transfer status is read only
// [RULE16] data memory in 32-byte pages
// [RULE17] scratchpad, secret, register page: 8 bytes
// [RULE18] write CRC16 covers address as sent
// [RULE19] copy done without partial means unrecognised write
// [RULE20] long low idles reset the device
package rts_pkg;
	////////////////////////////////////////////////////////////////////////////////
	// clock and slot timing, times in ns
	localparam int CLK_NS         = 4;
	localparam int T_RST_REG_NS   = 120000;
	localparam int T_RST_OD_NS    = 16000;
	localparam int T_SAMP_REG_NS  = 15000;
	localparam int T_SAMP_OD_NS   = 2000;
	localparam int T_HOLD_REG_NS  = 30000;
	localparam int T_HOLD_OD_NS   = 4000;
	localparam int T_PWAIT_REG_NS = 30000;
	localparam int T_PWAIT_OD_NS  = 4000;
	localparam int T_PLEN_REG_NS  = 60000;
	localparam int T_PLEN_OD_NS   = 8000;
	localparam int RST_OD_CYC     = (T_RST_OD_NS + CLK_NS - 1) / CLK_NS;
	localparam int SAMP_REG_CYC   = T_SAMP_REG_NS / CLK_NS;
	localparam int SAMP_OD_CYC    = T_SAMP_OD_NS / CLK_NS;
	localparam int HOLD_OD_CYC    = (T_HOLD_OD_NS + CLK_NS - 1) / CLK_NS;
	localparam int PWAIT_OD_CYC   = (T_PWAIT_OD_NS + CLK_NS - 1) / CLK_NS;
	localparam int PLEN_OD_CYC    = (T_PLEN_OD_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W          = 18;
	////////////////////////////////////////////////////////////////////////////////
	// identity code layout and CRC generators (reflected form)
	localparam int          FAM_W      = 8;
	localparam int          SER_W      = 48;
	localparam int          BODY_W     = 56;
	localparam int          ROM_W      = 64;
	localparam logic [5:0]  BODY_LAST  = 6'h37;
	localparam logic [7:0]  CRC8_POLY  = 8'h8C;
	localparam logic [15:0] CRC16_POLY = 16'hA001;
	////////////////////////////////////////////////////////////////////////////////
	// command codes
	localparam logic [7:0] CMD_READ_ROM  = 8'h33;
	localparam logic [7:0] CMD_MATCH_ROM = 8'h55;
	localparam logic [7:0] CMD_SRCH_ROM  = 8'hF0;
	localparam logic [7:0] CMD_SKIP_ROM  = 8'hCC;
	localparam logic [7:0] CMD_RESUME    = 8'hA5;
	localparam logic [7:0] CMD_OD_SKIP   = 8'h3C;
	localparam logic [7:0] CMD_OD_MATCH  = 8'h69;
	localparam logic [7:0] CMD_WR_SPAD   = 8'h0F;
	localparam logic [7:0] CMD_RD_SPAD   = 8'hAA;
	////////////////////////////////////////////////////////////////////////////////
	// address and transfer status layout, bit counts per phase
	localparam logic [7:0] TA_LOW_MASK  = 8'hF8;
	localparam logic [7:0] ES_ONES      = 8'h5F;
	localparam int         ES_AA_BIT    = 7;
	localparam int         ES_PF_BIT    = 5;
	localparam int         PAGE_SHIFT   = 5;
	localparam logic [7:0] PF_RESET     = 8'h01;
	localparam logic [6:0] LAST_BYTE    = 7'h07;
	localparam logic [6:0] LAST_WORD16  = 7'h0F;
	localparam logic [6:0] LAST_WORD64  = 7'h3F;
	localparam logic [6:0] LAST_RS      = 7'h57;
	localparam logic [3:0] RS_HDR_BYTES = 4'h3;
	localparam logic [1:0] SRCH_PH_WR   = 2'h2;

	typedef enum logic [3:0] {
		S_IDLE, S_ROMCMD, S_RDROM, S_MATCH, S_SRCH, S_FUNC,
		S_WSA, S_WSD, S_WSC, S_RS, S_WAIT
	} rts_state_t;

	typedef enum logic [1:0] {PR_IDLE, PR_WAIT, PR_DRIVE} rts_pres_t;
endpackage : rts_pkg

/* File: rts_spad_if.sv */
`timescale 1ns/1ps
// scratchpad port between the protocol engine and its storage
interface rts_spad_if;
	logic       we;
	logic [2:0] waddr;
	logic [7:0] wdata;
	logic [2:0] raddr;
	logic [7:0] rdata;
	modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : rts_spad_if

/* File: rts_spad_mem.sv */
`timescale 1ns/1ps
// eight-byte scratchpad, registered read data
module rts_spad_mem (
	input  wire logic clk_in,
	input  wire logic reset_n_in,
	rts_spad_if.mem   sp
);
	logic [7:0] mem_q [8];
	logic [7:0] rdata_q;

	// one write port per entry
	for (genvar i = 0; i < 8; i++) begin : g_ent
		always_ff @(posedge clk_in or negedge reset_n_in) begin
			if (!reset_n_in) begin
				mem_q[i] <= 8'h00;
			end else if (sp.we && (sp.waddr == 3'(i))) begin
				mem_q[i] <= sp.wdata;
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= mem_q[sp.raddr];
		end
	end

	assign sp.rdata = rdata_q;
endmodule : rts_spad_mem

/* File: rts_top.sv */
`timescale 1ns/1ps
// single-wire slave front end: identity code, ROM commands, scratchpad access
module rts_top #(
	parameter logic [7:0]  FAMILY_CODE     = 8'h5A,             // arbitrary value
	parameter logic [47:0] SERIAL_NUM      = 48'h0123_4567_89AB, // arbitrary value
	parameter int          RST_REG_CYC     = rts_pkg::T_RST_REG_NS / rts_pkg::CLK_NS,
	parameter int          HOLD_REG_CYC    = rts_pkg::T_HOLD_REG_NS / rts_pkg::CLK_NS,
	parameter int          PWAIT_REG_CYC   = rts_pkg::T_PWAIT_REG_NS / rts_pkg::CLK_NS,
	parameter int          PLEN_REG_CYC    = rts_pkg::T_PLEN_REG_NS / rts_pkg::CLK_NS
) (
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        dq_in,
	input  wire logic        copy_done_in,
	input  wire logic        power_lost_in,
	output logic             dq_out,
	output logic             dq_oe_out,
	output logic             overdrive_out,
	output logic      [15:0] target_addr_out,
	output logic      [10:0] page_out,
	output logic      [7:0]  status_out
);
	localparam int CW = rts_pkg::CNT_W;
	localparam logic [CW-1:0] RST_REG_C   = CW'(RST_REG_CYC);
	localparam logic [CW-1:0] RST_OD_C    = CW'(rts_pkg::RST_OD_CYC);
	localparam logic [CW-1:0] SAMP_REG_C  = CW'(rts_pkg::SAMP_REG_CYC);
	localparam logic [CW-1:0] SAMP_OD_C   = CW'(rts_pkg::SAMP_OD_CYC);
	localparam logic [CW-1:0] HOLD_REG_C  = CW'(HOLD_REG_CYC);
	localparam logic [CW-1:0] HOLD_OD_C   = CW'(rts_pkg::HOLD_OD_CYC);
	localparam logic [CW-1:0] PWAIT_REG_C = CW'(PWAIT_REG_CYC);
	localparam logic [CW-1:0] PWAIT_OD_C  = CW'(rts_pkg::PWAIT_OD_CYC);
	localparam logic [CW-1:0] PLEN_REG_C  = CW'(PLEN_REG_CYC);
	localparam logic [CW-1:0] PLEN_OD_C   = CW'(rts_pkg::PLEN_OD_CYC);

	rts_pkg::rts_state_t st_q, st_d;
	rts_pkg::rts_pres_t  pres_q, pres_d;
	logic [CW-1:0]  since_q, pres_cnt_q;
	logic [CW-1:0]  rst_thr, samp_thr, hold_thr, pwait_thr, plen_thr;
	logic           dq_prev_q, low_q, slot_q, pend_q, val_q, drv_q, drv_d;
	logic           fall, rise, fall_m, bus_rst, od_clr, bit_stb, bit_val;
	logic [6:0]     cnt_q, cnt_d;
	logic [63:0]    sh_q, sh_d;
	logic [1:0]     ph_q, ph_d;
	logic           od_q, od_d, res_q, res_d, aa_q, pf_q, aa_d, pf_d;
	logic [7:0]     ta_lo_q, ta_lo_d, ta_hi_q, ta_hi_d, byte_in, es_w, rs_byte;
	logic [63:0]    word_in, rom_full;
	logic [55:0]    rom_body;
	logic [5:0]     rom_idx_q;
	logic           rom_rdy_q, tx_act, tx_bit, crc16_en, crc16_clr, pf_done;
	logic [7:0]     crc8;
	logic [15:0]    crc16;
	rts_spad_if     sp ();

	////////////////////////////////////////////////////////////////////////////////
	// identity code, CRC computed once after reset from the fixed body
	assign rom_body = {SERIAL_NUM, FAMILY_CODE};           // [RULE1]
	assign rom_full = {crc8, rom_body};                    // [RULE1]

	rts_crc #(.W(8), .POLY(rts_pkg::CRC8_POLY)) u_crc8 (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.clr_in     (1'b0),
		.en_in      (~rom_rdy_q),
		.bit_in     (rom_body[rom_idx_q]),                 // [RULE2]
		.crc_out    (crc8)
	);

	// family LSB first, then serial; bus is ignored until this is done
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rom_idx_q <= 6'h00;
			rom_rdy_q <= 1'b0;
		end else if (!rom_rdy_q) begin
			rom_idx_q <= rom_idx_q + 6'h01;                   // [RULE2]
			rom_rdy_q <= (rom_idx_q == rts_pkg::BODY_LAST);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// slot timing: thresholds follow the current speed
	assign rst_thr   = od_q ? RST_OD_C : RST_REG_C;        // [RULE20]
	assign samp_thr  = od_q ? SAMP_OD_C : SAMP_REG_C;
	assign hold_thr  = od_q ? HOLD_OD_C : HOLD_REG_C;
	assign pwait_thr = od_q ? PWAIT_OD_C : PWAIT_REG_C;
	assign plen_thr  = od_q ? PLEN_OD_C : PLEN_REG_C;

	// edges; our own presence pulldown must not look like a master slot
	assign fall    = dq_prev_q & ~dq_in;
	assign rise    = ~dq_prev_q & dq_in;
	assign fall_m  = fall & (pres_q == rts_pkg::PR_IDLE) & rom_rdy_q;
	assign bus_rst = rise & low_q & (since_q >= rst_thr);  // [RULE20]
	assign od_clr  = rise & low_q & (since_q >= RST_REG_C);
	// a sampled bit is only delivered once the line is high again, so the
	// first part of a reset pulse never reaches the protocol as a zero
	assign bit_stb = pend_q & dq_in & ~bus_rst;
	assign bit_val = val_q;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			dq_prev_q <= 1'b1;
			since_q   <= '0;
			low_q     <= 1'b0;
		end else begin
			dq_prev_q <= dq_in;
			since_q   <= fall_m ? '0 : (since_q != '1) ? since_q + 1'b1 : since_q;
			low_q     <= fall_m | (low_q & ~rise);
		end
	end

	// sample point inside each slot, then wait for release
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			slot_q <= 1'b0;
			pend_q <= 1'b0;
			val_q  <= 1'b0;
		end else begin
			slot_q <= fall_m | (slot_q & ~(since_q == samp_thr) & ~bus_rst);
			pend_q <= (slot_q & (since_q == samp_thr)) | (pend_q & ~bit_stb & ~bus_rst);
			if (slot_q && (since_q == samp_thr)) begin
				val_q <= dq_in;
			end
		end
	end

	// presence pulse and transmit pulldown
	always_comb begin
		pres_d = pres_q;
		drv_d  = drv_q;
		case (pres_q)
			rts_pkg::PR_WAIT:  if (pres_cnt_q == pwait_thr) pres_d = rts_pkg::PR_DRIVE;
			rts_pkg::PR_DRIVE: if (pres_cnt_q == plen_thr) pres_d = rts_pkg::PR_IDLE;
			default:           pres_d = rts_pkg::PR_IDLE;
		endcase
		if (bus_rst) begin
			pres_d = rts_pkg::PR_WAIT;
			drv_d  = 1'b0;
		end else if (fall_m && tx_act && !tx_bit) begin
			drv_d = 1'b1;                                     // zero bits pull low
		end else if (since_q == hold_thr) begin
			drv_d = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pres_q     <= rts_pkg::PR_IDLE;
			pres_cnt_q <= '0;
			drv_q      <= 1'b0;
		end else begin
			pres_q     <= pres_d;
			pres_cnt_q <= (pres_d != pres_q) ? '0 : pres_cnt_q + 1'b1;
			drv_q      <= drv_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// transmit bit for the slot about to start
	assign rs_byte = (cnt_q[6:3] == 4'h0) ? ta_lo_q :
	                 (cnt_q[6:3] == 4'h1) ? ta_hi_q :
	                 (cnt_q[6:3] == 4'h2) ? es_w : sp.rdata;

	always_comb begin
		tx_act = 1'b1;
		tx_bit = 1'b1;
		case (st_q)
			rts_pkg::S_RDROM: tx_bit = rom_full[cnt_q[5:0]];   // [RULE4]
			rts_pkg::S_SRCH: begin
				tx_act = (ph_q != rts_pkg::SRCH_PH_WR);
				tx_bit = rom_full[cnt_q[5:0]] ^ ph_q[0];       // bit, then complement
			end
			rts_pkg::S_WSC:   tx_bit = ~crc16[cnt_q[3:0]];     // inverted CRC16
			rts_pkg::S_RS:    tx_bit = rs_byte[cnt_q[2:0]];    // [RULE4]
			default:          tx_act = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// protocol sequencing, one step per delivered bit
	assign byte_in = {bit_val, sh_q[63:57]};                // [RULE4]
	assign word_in = {bit_val, sh_q[63:1]};

	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		ph_d    = ph_q;
		od_d    = od_q;
		res_d   = res_q;
		ta_lo_d = ta_lo_q;
		ta_hi_d = ta_hi_q;
		if (bus_rst) begin
			st_d  = rts_pkg::S_ROMCMD;                        // [RULE5]
			cnt_d = 7'h00;
			ph_d  = 2'h0;
			if (od_clr) od_d = 1'b0;
		end else if (bit_stb) begin
			sh_d  = word_in;                                  // [RULE4]
			cnt_d = cnt_q + 7'h01;
			case (st_q)
				rts_pkg::S_ROMCMD: if (cnt_q == rts_pkg::LAST_BYTE) begin
					cnt_d = 7'h00;
					st_d  = rts_pkg::S_WAIT;
					case (byte_in)                                // [RULE5]
						rts_pkg::CMD_READ_ROM: begin st_d = rts_pkg::S_RDROM; res_d = 1'b0; end
						rts_pkg::CMD_MATCH_ROM: st_d = rts_pkg::S_MATCH;
						rts_pkg::CMD_SRCH_ROM:  st_d = rts_pkg::S_SRCH;
						rts_pkg::CMD_SKIP_ROM: begin st_d = rts_pkg::S_FUNC; res_d = 1'b0; end
						rts_pkg::CMD_RESUME: if (res_q) st_d = rts_pkg::S_FUNC;
						rts_pkg::CMD_OD_SKIP: begin
							st_d  = rts_pkg::S_FUNC;
							res_d = 1'b0;
							od_d  = 1'b1;                             // [RULE6]
						end
						rts_pkg::CMD_OD_MATCH: begin
							st_d = rts_pkg::S_MATCH;
							od_d = 1'b1;                              // [RULE6]
						end
						default: st_d = rts_pkg::S_WAIT;
					endcase
				end
				rts_pkg::S_RDROM: if (cnt_q == rts_pkg::LAST_WORD64) begin
					st_d  = rts_pkg::S_FUNC;
					cnt_d = 7'h00;
				end
				rts_pkg::S_MATCH: if (cnt_q == rts_pkg::LAST_WORD64) begin
					cnt_d = 7'h00;
					res_d = (word_in == rom_full);
					st_d  = (word_in == rom_full) ? rts_pkg::S_FUNC : rts_pkg::S_WAIT;
				end
				rts_pkg::S_SRCH: begin
					cnt_d = cnt_q;
					ph_d  = ph_q + 2'h1;
					if (ph_q == rts_pkg::SRCH_PH_WR) begin
						ph_d = 2'h0;
						if (bit_val != rom_full[cnt_q[5:0]]) begin
							st_d  = rts_pkg::S_WAIT;
							res_d = 1'b0;
						end else if (cnt_q == rts_pkg::LAST_WORD64) begin
							st_d  = rts_pkg::S_FUNC;
							res_d = 1'b1;
							cnt_d = 7'h00;
						end else begin
							cnt_d = cnt_q + 7'h01;
						end
					end
				end
				rts_pkg::S_FUNC: if (cnt_q == rts_pkg::LAST_BYTE) begin
					cnt_d = 7'h00;                                // [RULE7]
					st_d  = (byte_in == rts_pkg::CMD_WR_SPAD) ? rts_pkg::S_WSA :
					        (byte_in == rts_pkg::CMD_RD_SPAD) ? rts_pkg::S_RS : rts_pkg::S_WAIT;
				end
				rts_pkg::S_WSA: begin
					if (cnt_q == rts_pkg::LAST_BYTE) ta_lo_d = byte_in & rts_pkg::TA_LOW_MASK; // [RULE9]
					if (cnt_q == rts_pkg::LAST_WORD16) begin
						ta_hi_d = byte_in;                          // [RULE8]
						st_d    = rts_pkg::S_WSD;
						cnt_d   = 7'h00;
					end
				end
				rts_pkg::S_WSD: if (cnt_q == rts_pkg::LAST_WORD64) begin
					st_d  = rts_pkg::S_WSC;
					cnt_d = 7'h00;
				end
				rts_pkg::S_WSC: if (cnt_q == rts_pkg::LAST_WORD16) st_d = rts_pkg::S_WAIT;
				rts_pkg::S_RS:  if (cnt_q == rts_pkg::LAST_RS) st_d = rts_pkg::S_WAIT;
				default: cnt_d = cnt_q;                         // idle until next reset
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_q    <= rts_pkg::S_IDLE;
			cnt_q   <= 7'h00;
			sh_q    <= '0;
			ph_q    <= 2'h0;
			od_q    <= 1'b0;
			res_q   <= 1'b0;
			ta_lo_q <= 8'h00;
			ta_hi_q <= 8'h00;
		end else begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			ph_q    <= ph_d;
			od_q    <= od_d;
			res_q   <= res_d;
			ta_lo_q <= ta_lo_d;
			ta_hi_q <= ta_hi_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// write CRC sees command and address exactly as received, before masking
	assign crc16_clr = bit_stb & (st_d == rts_pkg::S_FUNC) & (st_q != rts_pkg::S_FUNC);
	assign crc16_en  = bit_stb & ((st_q == rts_pkg::S_FUNC) | (st_q == rts_pkg::S_WSA) |
	                              (st_q == rts_pkg::S_WSD));         // [RULE18]

	rts_crc #(.W(16), .POLY(rts_pkg::CRC16_POLY)) u_crc16 (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.clr_in     (crc16_clr),
		.en_in      (crc16_en),
		.bit_in     (bit_val),
		.crc_out    (crc16)
	);

	// scratchpad storage, eight bytes
	assign sp.we    = bit_stb & (st_q == rts_pkg::S_WSD) & (cnt_q[2:0] == 3'h7); // [RULE17]
	assign sp.waddr = cnt_q[5:3];
	assign sp.wdata = byte_in;
	assign sp.raddr = 3'(cnt_q[6:3] - rts_pkg::RS_HDR_BYTES);

	rts_spad_mem u_spad (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.sp         (sp.mem)
	);

	////////////////////////////////////////////////////////////////////////////////
	// transfer status; hardware sets win over clears in the same cycle
	assign pf_done = bit_stb & (st_q == rts_pkg::S_WSD) & (cnt_q == rts_pkg::LAST_WORD64);
	assign aa_d = copy_done_in | (aa_q & ~sp.we);           // [RULE14]
	assign pf_d = power_lost_in ? 1'b1 :                    // [RULE11]
	              (bus_rst && st_q == rts_pkg::S_WSD && cnt_q != 7'h00) ?
	              (cnt_q[2:0] != 3'h0) :                    // [RULE11]
	              pf_done ? 1'b0 : pf_q;                    // [RULE12]

	// no write path reaches this register
	always_comb begin
		es_w                     = rts_pkg::ES_ONES;        // [RULE10] [RULE13] [RULE15]
		es_w[rts_pkg::ES_AA_BIT] = aa_q;
		es_w[rts_pkg::ES_PF_BIT] = pf_q;
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			aa_q <= 1'b0;
			pf_q <= rts_pkg::PF_RESET[0];                       // nothing valid after power-up
		end else begin
			aa_q <= aa_d;
			pf_q <= pf_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered outputs; the pin only ever pulls low
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			dq_out          <= 1'b0;
			dq_oe_out       <= 1'b0;
			overdrive_out   <= 1'b0;
			target_addr_out <= 16'h0000;
			page_out        <= 11'h000;
			status_out      <= 8'h00;
		end else begin
			dq_out          <= 1'b0;
			dq_oe_out       <= drv_d | (pres_d == rts_pkg::PR_DRIVE);
			overdrive_out   <= od_q;
			target_addr_out <= {ta_hi_q, ta_lo_q};
			page_out        <= 11'({ta_hi_q, ta_lo_q} >> rts_pkg::PAGE_SHIFT); // [RULE16]
			status_out      <= es_w;
		end
	end
endmodule : rts_top

/* File: rts_top_monitor.sv */
`timescale 1ns/1ps
// passive watcher on the front end's pins, one clock domain
module rts_top_monitor (
	input wire logic        clk_in,
	input wire logic        reset_n_in,
	input wire logic        dq_in,
	input wire logic        copy_done_in,
	input wire logic        power_lost_in,
	input wire logic        dq_out,
	input wire logic        dq_oe_out,
	input wire logic        overdrive_out,
	input wire logic [15:0] target_addr_out,
	input wire logic [10:0] page_out,
	input wire logic [7:0]  status_out
);
	default clocking mon_cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	// status constants; skip the first edge after release, the flops load there
	ending_ones_a: assert property ($past(reset_n_in) |-> status_out[2:0] == 3'h7)
		else $error("ending offset bits not all ones");
	fixed_ones_a: assert property ($past(reset_n_in) |-> status_out[6] && status_out[4:3] == 2'h3)
		else $error("unused status bits not one");

	// address shape; page and address load on the same edge, and page is only judged while the address is stable
	addr_align_a: assert property (target_addr_out[2:0] == 3'h0)
		else $error("target address not block aligned");
	page_map_a: assert property ($past(reset_n_in) && $stable(target_addr_out) |-> page_out == target_addr_out[15:5])
		else $error("page does not follow target address");

	// flag causes: set wins over clear; the pin register trails the flag by one edge
	copy_set_a: assert property (copy_done_in |-> ##2 status_out[7])
		else $error("copy done pulse did not set flag");
	copy_rise_a: assert property ($rose(status_out[7]) |-> $past(copy_done_in, 2))
		else $error("copy done flag rose without a copy");
	power_pf_a: assert property (power_lost_in |-> ##2 status_out[5])
		else $error("power loss did not set partial flag");

	// speed change lands only once the command byte's last slot is over
	od_entry_a: assert property ($rose(overdrive_out) |-> dq_in)
		else $error("overdrive entered while line low");
endmodule : rts_top_monitor

bind rts_top rts_top_monitor mon (
	.clk_in(clk_in), .reset_n_in(reset_n_in), .dq_in(dq_in),
	.copy_done_in(copy_done_in), .power_lost_in(power_lost_in),
	.dq_out(dq_out), .dq_oe_out(dq_oe_out), .overdrive_out(overdrive_out),
	.target_addr_out(target_addr_out), .page_out(page_out), .status_out(status_out)
);
